// ---- design/fsb_sig_pkg.sv ----
package fsb_sig_pkg;

  // clock and reset timing
  localparam int CORE_CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int RESET_EXT_MS = 1;
  localparam int RESET_EXT_CYCLES = RESET_EXT_MS * (CORE_CLK_HZ / MS_PER_S);
  localparam int RST_CNT_W = 32;
  // core_clk is the host clock, so host-clock figures are cycle counts directly
  localparam int BREQ_SETUP_HCLK = 4;
  localparam int BREQ_HOLD_MIN_HCLK = 2;
  localparam int BREQ_HOLD_MAX_HCLK = 20;
  localparam int BREQ_HOLD_HCLK = BREQ_HOLD_MIN_HCLK + 2;
  localparam int BREQ_CNT_W = 5;

  // data path: four 64-bit beats per host clock, four 16-bit lanes per beat
  localparam int BEATS = 4;
  localparam int BEAT_W = 64;
  localparam int LANE_W = 16;
  localparam int WORD_W = BEATS * BEAT_W;
  localparam int LANES = WORD_W / LANE_W;
  localparam int FLAG_W = LANES;
  localparam int LANE_LOW_MAX = 8;
  localparam int LANE_CNT_W = 5;

  // control pin indices on the shared open-drain control group
  localparam int CTL_STROBE = 0;
  localparam int CTL_BNR = 1;
  localparam int CTL_PRI = 2;
  localparam int CTL_BREQ = 3;
  localparam int CTL_RST = 4;
  localparam int CTL_HOLD = 5;
  localparam int CTL_DEFER = 6;
  localparam int CTL_DATA_VALID_STROBE = 7;
  localparam int CTL_LOCK = 8;
  localparam int CTL_W = 9;
  localparam logic [CTL_W-1:0] CTL_NONE = 9'h000;
  localparam logic [CTL_W-1:0] CTL_RESET_ON = 9'h018;

  typedef enum logic [1:0] {
    FREQ_100_400 = 2'h0,
    FREQ_133_533 = 2'h1,
    FREQ_200_800 = 2'h2,
    FREQ_RESERVED = 2'h3
  } freq_type;

  typedef enum logic [3:0] {
    PRI_IDLE = 4'h1,
    PRI_ASK = 4'h2,
    PRI_STROBE = 4'h4,
    PRI_SECOND = 4'h8
  } pri_state_type;

  typedef enum logic [2:0] {
    CPU_IDLE = 3'h1,
    CPU_REQ1 = 3'h2,
    CPU_REQ2 = 3'h4
  } cpu_state_type;

  // returns {flag level, lane levels}; a logical 1 travels as a low level
  function automatic logic [LANE_W:0] lane_encode(input logic [LANE_W-1:0] d);
    logic [LANE_CNT_W-1:0] ones;
    ones = '0;
    for (int i = 0; i < LANE_W; i++) begin
      ones = ones + LANE_CNT_W'(d[i]);
    end
    if (ones > LANE_CNT_W'(LANE_LOW_MAX)) begin
      lane_encode = {1'b0, d};
    end else begin
      lane_encode = {1'b1, ~d};
    end
  endfunction : lane_encode

  // undo lane inversion first, then the bus polarity
  function automatic logic [LANE_W-1:0] lane_decode(input logic [LANE_W-1:0] lvl,
                                                    input logic flag_lvl);
    lane_decode = ~(lvl ^ {LANE_W{~flag_lvl}});
  endfunction : lane_decode

  function automatic logic [FLAG_W+WORD_W-1:0] word_encode(input logic [WORD_W-1:0] w);
    logic [LANE_W:0] e;
    e = '0;
    word_encode = '0;
    for (int l = 0; l < LANES; l++) begin
      e = lane_encode(w[l*LANE_W +: LANE_W]);
      word_encode[l*LANE_W +: LANE_W] = e[LANE_W-1:0];
      word_encode[WORD_W+l] = e[LANE_W];
    end
  endfunction : word_encode

  function automatic logic [WORD_W-1:0] word_decode(input logic [WORD_W-1:0] lvl,
                                                    input logic [FLAG_W-1:0] flg);
    word_decode = '0;
    for (int l = 0; l < LANES; l++) begin
      word_decode[l*LANE_W +: LANE_W] = lane_decode(lvl[l*LANE_W +: LANE_W], flg[l]);
    end
  endfunction : word_decode

endpackage : fsb_sig_pkg

// ---- design/fsb_link_if.sv ----
`timescale 1ns/100ps
interface fsb_link_if import fsb_sig_pkg::*; ;
  logic [CTL_W-1:0] hub_ctl_o;
  logic [CTL_W-1:0] hub_ctl_oe;
  logic [CTL_W-1:0] cpu_ctl_o;
  logic [CTL_W-1:0] cpu_ctl_oe;
  logic [CTL_W-1:0] ctl_n;
  logic [WORD_W-1:0] hub_dat_o;
  logic [WORD_W-1:0] hub_dat_oe;
  logic [WORD_W-1:0] cpu_dat_o;
  logic [WORD_W-1:0] cpu_dat_oe;
  logic [WORD_W-1:0] bus_dat_lvl;
  logic [FLAG_W-1:0] hub_flg_o;
  logic [FLAG_W-1:0] hub_flg_oe;
  logic [FLAG_W-1:0] cpu_flg_o;
  logic [FLAG_W-1:0] cpu_flg_oe;
  logic [FLAG_W-1:0] bus_flg_lvl;

  // open-drain wires with termination: low when any party drives low
  assign ctl_n = ~((hub_ctl_oe & ~hub_ctl_o) | (cpu_ctl_oe & ~cpu_ctl_o));
  assign bus_dat_lvl = ~((hub_dat_oe & ~hub_dat_o) | (cpu_dat_oe & ~cpu_dat_o));
  assign bus_flg_lvl = ~((hub_flg_oe & ~hub_flg_o) | (cpu_flg_oe & ~cpu_flg_o));

  modport hub (
    output hub_ctl_o, hub_ctl_oe, hub_dat_o, hub_dat_oe, hub_flg_o, hub_flg_oe,
    input ctl_n, bus_dat_lvl, bus_flg_lvl
  );
  modport cpu (
    output cpu_ctl_o, cpu_ctl_oe, cpu_dat_o, cpu_dat_oe, cpu_flg_o, cpu_flg_oe,
    input ctl_n, bus_dat_lvl, bus_flg_lvl
  );
endinterface : fsb_link_if

// ---- design/cpu_bus_agent.sv ----
`timescale 1ns/100ps
module cpu_bus_agent import fsb_sig_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  fsb_link_if.cpu link,
  input wire logic req_valid,
  output logic req_ack,
  output logic req_deferred,
  input wire logic lock_req,
  input wire logic throttle,
  input wire logic tx_valid,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic [WORD_W-1:0] rx_data,
  output logic in_reset,
  output logic agent_zero
);
  cpu_state_type state_q, state_d;
  logic [CTL_W-1:0] ctl_on_d, ctl_on_q, ctl_o_q, ctl_oe_q;
  logic [WORD_W-1:0] dat_o_q, dat_oe_q, rx_data_q;
  logic [FLAG_W-1:0] flg_o_q, flg_oe_q;
  logic req_ack_q, req_deferred_q, tx_ready_q, rx_valid_q, in_reset_q, agent_zero_q;

  wire logic [CTL_W-1:0] seen = ~link.ctl_n;
  wire logic [CTL_W-1:0] other_on = seen & ~ctl_on_q;
  wire logic rst_seen = seen[CTL_RST];
  wire logic locked = ctl_on_q[CTL_LOCK];
  // a locked sequence may go on under priority; a blocked bus may not
  wire logic may_issue = ~rst_seen & ~other_on[CTL_BNR] & (~seen[CTL_PRI] | locked)
                         & ~other_on[CTL_STROBE];
  wire logic tx_accept = tx_valid & tx_ready_q;
  wire logic [FLAG_W+WORD_W-1:0] tx_enc = word_encode(tx_data);

  always_comb begin
    state_d = state_q;
    case (state_q)
      CPU_IDLE: if (req_valid & may_issue) state_d = CPU_REQ1;
      CPU_REQ1: state_d = CPU_REQ2;
      CPU_REQ2: state_d = CPU_IDLE;
      default: state_d = CPU_IDLE;
    endcase
    if (rst_seen) state_d = CPU_IDLE;
  end

  always_comb begin
    ctl_on_d = CTL_NONE;
    ctl_on_d[CTL_STROBE] = (state_d == CPU_REQ1);
    ctl_on_d[CTL_BNR] = throttle & ~rst_seen;
    ctl_on_d[CTL_LOCK] = lock_req & ~rst_seen;
    ctl_on_d[CTL_DATA_VALID_STROBE] = tx_accept;
    ctl_on_d[CTL_HOLD] = tx_accept & ~tx_last;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= CPU_IDLE;
      ctl_on_q <= CTL_NONE;
      ctl_o_q <= ~CTL_NONE;
      ctl_oe_q <= CTL_NONE;
    end else begin
      state_q <= state_d;
      ctl_on_q <= ctl_on_d;
      ctl_o_q <= ~ctl_on_d;
      ctl_oe_q <= ctl_on_d | ctl_on_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dat_o_q <= '0;
      dat_oe_q <= '0;
      flg_o_q <= '0;
      flg_oe_q <= '0;
      tx_ready_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
    end else begin
      dat_o_q <= tx_enc[WORD_W-1:0];
      flg_o_q <= tx_enc[FLAG_W+WORD_W-1:WORD_W];
      dat_oe_q <= {WORD_W{tx_accept}};
      flg_oe_q <= {FLAG_W{tx_accept}};
      tx_ready_q <= ~rst_seen & ~other_on[CTL_HOLD] & ~other_on[CTL_DATA_VALID_STROBE];
      rx_valid_q <= other_on[CTL_DATA_VALID_STROBE];
      if (other_on[CTL_DATA_VALID_STROBE]) rx_data_q <= word_decode(link.bus_dat_lvl, link.bus_flg_lvl);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_ack_q <= 1'b0;
      req_deferred_q <= 1'b0;
      in_reset_q <= 1'b1;
      agent_zero_q <= 1'b0;
    end else begin
      req_ack_q <= (state_d == CPU_REQ2);
      req_deferred_q <= other_on[CTL_DEFER];
      in_reset_q <= rst_seen;
      // the agent id is taken on the first cycle out of reset
      if (in_reset_q & ~rst_seen) agent_zero_q <= seen[CTL_BREQ];
    end
  end

  assign link.cpu_ctl_o = ctl_o_q;
  assign link.cpu_ctl_oe = ctl_oe_q;
  assign link.cpu_dat_o = dat_o_q;
  assign link.cpu_dat_oe = dat_oe_q;
  assign link.cpu_flg_o = flg_o_q;
  assign link.cpu_flg_oe = flg_oe_q;
  assign req_ack = req_ack_q;
  assign req_deferred = req_deferred_q;
  assign tx_ready = tx_ready_q;
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign in_reset = in_reset_q;
  assign agent_zero = agent_zero_q;
endmodule : cpu_bus_agent

// ---- design/hub_bus_agent.sv ----
`timescale 1ns/100ps
module hub_bus_agent import fsb_sig_pkg::*; #(
  parameter int unsigned RST_EXT_CYCLES = RESET_EXT_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  fsb_link_if.hub link,
  input wire logic system_reset_in_n,
  input wire logic power_good,
  input wire logic [1:0] bus_frequency_strap,
  output logic [1:0] bus_frequency_select,
  output logic freq_reserved,
  output logic processor_in_reset,
  input wire logic snoop_req,
  output logic snoop_ack,
  input wire logic defer_req,
  input wire logic throttle,
  input wire logic tx_valid,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic [WORD_W-1:0] rx_data
);
  pri_state_type state_q, state_d;
  logic [CTL_W-1:0] ctl_on_d, ctl_on_q, ctl_o_q, ctl_oe_q;
  logic [WORD_W-1:0] dat_o_q, dat_oe_q, rx_data_q;
  logic [FLAG_W-1:0] flg_o_q, flg_oe_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  logic [BREQ_CNT_W-1:0] breq_cnt_q;
  logic [1:0] freq_q;
  logic pg_q, freq_rsv_q, proc_rst_q;
  logic strobe_other_q, def_pend_q, snoop_ack_q, tx_ready_q, rx_valid_q;

  wire logic [CTL_W-1:0] seen = ~link.ctl_n;
  // what the far end drives, with our own drive masked out
  wire logic [CTL_W-1:0] other_on = seen & ~ctl_on_q;
  wire logic strobe_other = other_on[CTL_STROBE];

  // processor reset and the request window around its release, held through the whole reset
  // breq stays low BREQ_HOLD_HCLK cycles past the reset edge, inside the 2..20
  // window, so a processor that samples a little late still sees it low
  wire logic rst_ext_busy = (rst_cnt_q != '0);
  wire logic proc_rst_on = ~system_reset_in_n | rst_ext_busy;
  wire logic breq_on = proc_rst_on | (breq_cnt_q != '0);

  // the extension restarts whenever the system reset input is seen low again
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_q <= RST_CNT_W'(RST_EXT_CYCLES);
    end else if (!system_reset_in_n) begin
      rst_cnt_q <= RST_CNT_W'(RST_EXT_CYCLES);
    end else if (rst_ext_busy) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end

  // reload for the whole reset, so the setup side is always met
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      breq_cnt_q <= BREQ_CNT_W'(BREQ_HOLD_HCLK);
    end else if (proc_rst_on) begin
      breq_cnt_q <= BREQ_CNT_W'(BREQ_HOLD_HCLK);
    end else if (breq_cnt_q != '0) begin
      breq_cnt_q <= breq_cnt_q - 1'b1;
    end
  end

  // strap latch; power_good is taken as synchronous to core_clk
  // limitation: the reserved code is latched as is and only flagged to the user
  wire logic pg_rise = power_good & ~pg_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pg_q <= 1'b0;
      freq_q <= FREQ_100_400;
      freq_rsv_q <= 1'b0;
    end else begin
      pg_q <= power_good;
      if (pg_rise) begin
        freq_q <= bus_frequency_strap;
        freq_rsv_q <= (bus_frequency_strap == FREQ_RESERVED);
      end
    end
  end

  // priority request for snoop cycles
  // priority stays shown until the second request cycle, then is driven high once
  wire logic req_in_flight = strobe_other | strobe_other_q;
  // a processor strobe now or one cycle ago means its request phase is still open
  // a locked sequence or a blocked bus keeps us waiting behind priority
  wire logic bus_clear = ~req_in_flight & ~seen[CTL_LOCK] & ~other_on[CTL_BNR];
  wire logic pri_owned = ctl_on_q[CTL_PRI];

  always_comb begin
    state_d = state_q;
    case (state_q)
      PRI_IDLE: if (snoop_req & ~proc_rst_on) state_d = PRI_ASK;
      PRI_ASK: if (pri_owned & bus_clear) state_d = PRI_STROBE;
      PRI_STROBE: state_d = PRI_SECOND;
      PRI_SECOND: state_d = PRI_IDLE;
      default: state_d = PRI_IDLE;
    endcase
    if (proc_rst_on) state_d = PRI_IDLE;
  end

  wire logic tx_accept = tx_valid & tx_ready_q;
  wire logic [FLAG_W+WORD_W-1:0] tx_enc = word_encode(tx_data);

  // pin levels follow the next state, so each pin changes on the edge entering it
  always_comb begin
    ctl_on_d = CTL_NONE;
    ctl_on_d[CTL_STROBE] = (state_d == PRI_STROBE);
    ctl_on_d[CTL_PRI] = (state_d != PRI_IDLE);
    ctl_on_d[CTL_BNR] = throttle & ~proc_rst_on;
    ctl_on_d[CTL_BREQ] = breq_on;
    ctl_on_d[CTL_RST] = proc_rst_on;
    ctl_on_d[CTL_DEFER] = def_pend_q;
    ctl_on_d[CTL_DATA_VALID_STROBE] = tx_accept;
    ctl_on_d[CTL_HOLD] = tx_accept & ~tx_last;
  end

  // one extra cycle of high drive after deassert avoids a slow pull-up edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PRI_IDLE;
      ctl_on_q <= CTL_RESET_ON;
      ctl_o_q <= ~CTL_RESET_ON;
      ctl_oe_q <= CTL_RESET_ON;
    end else begin
      state_q <= state_d;
      ctl_on_q <= ctl_on_d;
      ctl_o_q <= ~ctl_on_d;
      ctl_oe_q <= ctl_on_d | ctl_on_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_other_q <= 1'b0;
      def_pend_q <= 1'b0;
      snoop_ack_q <= 1'b0;
      proc_rst_q <= 1'b1;
    end else begin
      strobe_other_q <= strobe_other;
      // decision taken with the first request cycle, shown in the snoop cycle
      def_pend_q <= strobe_other & defer_req;
      snoop_ack_q <= (state_d == PRI_SECOND);
      proc_rst_q <= proc_rst_on;
    end
  end

  // data path; the data bus is open-drain, so the whole word is driven
  // ready drops for a cycle when the far end shows hold or data ready;
  // both ends starting in the same cycle is left to the users to arbitrate
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dat_o_q <= '0;
      dat_oe_q <= '0;
      flg_o_q <= '0;
      flg_oe_q <= '0;
      tx_ready_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
    end else begin
      dat_o_q <= tx_enc[WORD_W-1:0];
      flg_o_q <= tx_enc[FLAG_W+WORD_W-1:WORD_W];
      dat_oe_q <= {WORD_W{tx_accept}};
      flg_oe_q <= {FLAG_W{tx_accept}};
      tx_ready_q <= ~proc_rst_on & ~other_on[CTL_HOLD] & ~other_on[CTL_DATA_VALID_STROBE];
      rx_valid_q <= other_on[CTL_DATA_VALID_STROBE];
      if (other_on[CTL_DATA_VALID_STROBE]) begin
        rx_data_q <= word_decode(link.bus_dat_lvl, link.bus_flg_lvl);
      end
    end
  end

  assign link.hub_ctl_o = ctl_o_q;
  assign link.hub_ctl_oe = ctl_oe_q;
  assign link.hub_dat_o = dat_o_q;
  assign link.hub_dat_oe = dat_oe_q;
  assign link.hub_flg_o = flg_o_q;
  assign link.hub_flg_oe = flg_oe_q;
  assign bus_frequency_select = freq_q;
  assign freq_reserved = freq_rsv_q;
  assign processor_in_reset = proc_rst_q;
  assign snoop_ack = snoop_ack_q;
  assign tx_ready = tx_ready_q;
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
endmodule : hub_bus_agent

// ---- sim/host_bus_agent_signalling_checker.sv ----
`timescale 1ns/100ps
module host_bus_agent_signalling_checker import fsb_sig_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [CTL_W-1:0] hub_ctl_o,
  input wire logic [CTL_W-1:0] hub_ctl_oe,
  input wire logic [CTL_W-1:0] cpu_ctl_oe,
  input wire logic [CTL_W-1:0] ctl_n,
  input wire logic [WORD_W-1:0] hub_dat_oe,
  input wire logic [WORD_W-1:0] bus_dat_lvl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic lanes_ok;
  always_comb begin
    lanes_ok = 1'b1;
    for (int l = 0; l < LANES; l++) begin
      if ($countones(~bus_dat_lvl[l*LANE_W +: LANE_W]) > LANE_LOW_MAX) lanes_ok = 1'b0;
    end
  end

  // low for BREQ_HOLD_HCLK samples from the one that first sees reset off
  sequence breq_hold_s;
    !ctl_n[CTL_BREQ] [*4] ##1 ctl_n[CTL_BREQ];
  endsequence
  sequence breq_release_s;
    hub_ctl_oe[CTL_BREQ] ##1 !hub_ctl_oe[CTL_BREQ];
  endsequence
  sequence cpu_strobe_s;
    !ctl_n[CTL_STROBE] && cpu_ctl_oe[CTL_STROBE];
  endsequence

  breq_in_reset_a: assert property (!ctl_n[CTL_RST] |-> !ctl_n[CTL_BREQ])
    else $error("request zero not low during processor reset");
  breq_hold_a: assert property ($rose(ctl_n[CTL_RST]) |-> breq_hold_s)
    else $error("request zero hold after reset release wrong");
  breq_release_a: assert property ($rose(ctl_n[CTL_BREQ]) |-> breq_release_s)
    else $error("request zero not released after hold");
  drive_before_release_a: assert property
    ((($past(hub_ctl_oe) & ~hub_ctl_oe) & ~$past(hub_ctl_o)) == '0)
    else $error("control released straight from active level");
  strobe_after_pri_a: assert property
    (!ctl_n[CTL_STROBE] && hub_ctl_oe[CTL_STROBE] |-> !$past(ctl_n[CTL_PRI]))
    else $error("hub strobe without priority request shown");
  cpu_yields_pri_a: assert property
    (cpu_strobe_s |-> $past(ctl_n[CTL_PRI]) || !$past(ctl_n[CTL_LOCK]))
    else $error("processor strobe during priority request");
  cpu_not_blocked_a: assert property (cpu_strobe_s |-> $past(ctl_n[CTL_BNR]))
    else $error("processor strobe while blocked");
  strobe_in_reset_a: assert property (!ctl_n[CTL_RST] |-> ctl_n[CTL_STROBE])
    else $error("strobe during processor reset");
  data_valid_strobe_with_data_a: assert property ((|hub_dat_oe) |-> !ctl_n[CTL_DATA_VALID_STROBE])
    else $error("data driven without data ready");
  lane_lows_a: assert property (!ctl_n[CTL_DATA_VALID_STROBE] |-> lanes_ok)
    else $error("lane with more than eight low bits");
  defer_pulse_a: assert property ($fell(ctl_n[CTL_DEFER]) |->
    (!$past(ctl_n[CTL_STROBE], 2) || !$past(ctl_n[CTL_STROBE], 3)) ##1 ctl_n[CTL_DEFER])
    else $error("defer not a single cycle after a strobe");
endmodule : host_bus_agent_signalling_checker

// ---- sim/host_bus_agent_signalling_bench.sv ----
`timescale 1ns/100ps
module host_bus_agent_signalling_bench import fsb_sig_pkg::*; ;
  localparam int EXT = 8;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sys_n = 1'b1, pgood = 1'b0, snoop_req = 1'b0, defer_req = 1'b0, h_thr = 1'b0;
  logic c_req = 1'b0, c_thr = 1'b0, h_txv = 1'b0, c_txv = 1'b0, h_last = 1'b0;
  logic c_last = 1'b0, c_lock = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [WORD_W-1:0] h_txd = '0, c_txd = '0, h_rxd, c_rxd;
  logic [1:0] sel;
  logic fres, pin_rst, snoop_ack, h_rdy, h_rxv, c_ack, c_def, c_rdy, c_rxv, c_inrst, c_zero;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_def = 0;
  logic [WORD_W-1:0] c_q[$], h_q[$], lvl_q[$];
  logic [FLAG_W:0] flg_q[$];

  initial forever #12.5 core_clk = ~core_clk;

  fsb_link_if lnk ();
  hub_bus_agent #(.RST_EXT_CYCLES(EXT)) i_hub_bus_agent (.core_clk(core_clk), .nrst(nrst),
    .link(lnk), .system_reset_in_n(sys_n), .power_good(pgood), .bus_frequency_strap(strap),
    .bus_frequency_select(sel), .freq_reserved(fres), .processor_in_reset(pin_rst),
    .snoop_req(snoop_req), .snoop_ack(snoop_ack), .defer_req(defer_req), .throttle(h_thr),
    .tx_valid(h_txv), .tx_data(h_txd), .tx_last(h_last), .tx_ready(h_rdy),
    .rx_valid(h_rxv), .rx_data(h_rxd));
  cpu_bus_agent i_cpu_bus_agent (.core_clk(core_clk), .nrst(nrst), .link(lnk),
    .req_valid(c_req), .req_ack(c_ack), .req_deferred(c_def), .lock_req(c_lock),
    .throttle(c_thr), .tx_valid(c_txv), .tx_data(c_txd), .tx_last(c_last), .tx_ready(c_rdy),
    .rx_valid(c_rxv), .rx_data(c_rxd), .in_reset(c_inrst), .agent_zero(c_zero));
  host_bus_agent_signalling_checker i_checker (.core_clk(core_clk), .nrst(nrst),
    .hub_ctl_o(lnk.hub_ctl_o), .hub_ctl_oe(lnk.hub_ctl_oe), .cpu_ctl_oe(lnk.cpu_ctl_oe),
    .ctl_n(lnk.ctl_n), .hub_dat_oe(lnk.hub_dat_oe), .bus_dat_lvl(lnk.bus_dat_lvl));

  // sampled mid-cycle so flop updates of the rising edge have landed
  always @(negedge core_clk) begin
    if (c_rxv === 1'b1) c_q.push_back(c_rxd);
    if (h_rxv === 1'b1) h_q.push_back(h_rxd);
    if (c_def === 1'b1) n_def++;
    if (lnk.ctl_n[CTL_DATA_VALID_STROBE] === 1'b0) begin
      lvl_q.push_back(lnk.bus_dat_lvl);
      flg_q.push_back({lnk.ctl_n[CTL_HOLD], lnk.bus_flg_lvl});
    end
  end

  task automatic chk(input logic [WORD_W-1:0] act, input logic [WORD_W-1:0] exp);
    n_tests++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, act, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_hi

  task automatic rst_wait;
    int n;
    n = 0;
    while (lnk.ctl_n[CTL_RST] !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(WORD_W'(n >= EXT && n <= EXT + 4), 1'b1);
    repeat (8) @(negedge core_clk);
    chk({c_inrst, pin_rst, c_zero, lnk.ctl_n[CTL_BREQ]}, 4'h3);
  endtask : rst_wait

  task automatic t_sysrst;
    sys_n = 1'b0;
    repeat (3) @(negedge core_clk);
    repeat (20) begin
      @(negedge core_clk);
      chk({lnk.ctl_n[CTL_RST], lnk.ctl_n[CTL_BREQ], pin_rst}, 3'h1);
      chk({h_rdy, c_rdy}, 2'h0);
    end
    sys_n = 1'b1;
    rst_wait();
  endtask : t_sysrst

  task automatic t_strap;
    for (int c = 0; c < 4; c++) begin
      strap = 2'(c);
      pgood = 1'b1;
      repeat (2) @(negedge core_clk);
      // a strap change with no power-good rise must not reach the select
      strap = ~strap;
      pgood = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({fres, sel}, {c == 3, 2'(c)});
    end
  endtask : t_strap

  task automatic t_snoop(input logic blk);
    c_thr = blk;
    @(negedge core_clk);
    snoop_req = 1'b1;
    wait_hi(snoop_ack, 10);
    chk(snoop_ack, !blk);
    c_thr = 1'b0;
    wait_hi(snoop_ack, 10);
    chk(snoop_ack, 1'b1);
    snoop_req = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : t_snoop

  task automatic t_req(input logic dfr, input logic blk);
    int n0;
    n0 = n_def;
    {defer_req, h_thr} = {dfr, blk};
    @(negedge core_clk);
    c_req = 1'b1;
    wait_hi(c_ack, 10);
    chk(c_ack, !blk);
    h_thr = 1'b0;
    wait_hi(c_ack, 10);
    chk(c_ack, 1'b1);
    c_req = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(n_def != n0, dfr);
    defer_req = 1'b0;
  endtask : t_req

  // a locked processor may go on under priority; the hub waits for the unlock
  task automatic t_lock;
    c_lock = 1'b1;
    @(negedge core_clk);
    snoop_req = 1'b1;
    repeat (3) @(negedge core_clk);
    c_req = 1'b1;
    wait_hi(c_ack, 10);
    chk(c_ack, 1'b1);
    chk(snoop_ack, 1'b0);
    {c_req, c_lock} = 2'h0;
    wait_hi(snoop_ack, 10);
    chk(snoop_ack, 1'b1);
    snoop_req = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : t_lock

  task automatic t_data(input logic to_cpu);
    logic [WORD_W-1:0] w[4];
    logic [WORD_W-1:0] lvl;
    logic [FLAG_W:0] flg;
    logic [LANE_W-1:0] d;
    w = '{{WORD_W{1'b0}}, {WORD_W{1'b1}}, {8{16'h01FF, 16'h00FF}},
          {4{64'h0123_4567_89AB_CDEF}}};
    lvl_q.delete();
    flg_q.delete();
    c_q.delete();
    h_q.delete();
    for (int i = 0; i < 4; i++) begin
      if (to_cpu) {h_txv, h_txd, h_last} = {1'b1, w[i], i == 3};
      else {c_txv, c_txd, c_last} = {1'b1, w[i], i == 3};
      if (to_cpu) wait_hi(h_rdy, 20);
      else wait_hi(c_rdy, 20);
      @(negedge core_clk);
    end
    {h_txv, c_txv} = 2'h0;
    repeat (4) @(negedge core_clk);
    chk(lvl_q.size(), 4);
    for (int i = 0; i < 4; i++) begin
      for (int l = 0; l < LANES; l++) begin
        d = w[i][l*LANE_W +: LANE_W];
        flg[l] = $countones(d) <= LANE_LOW_MAX;
        lvl[l*LANE_W +: LANE_W] = flg[l] ? ~d : d;
      end
      flg[FLAG_W] = i == 3;
      chk(to_cpu ? c_q[i] : h_q[i], w[i]);
      chk(lvl_q[i], lvl);
      chk(flg_q[i], flg);
    end
  endtask : t_data

  initial begin
    strap = 2'h2;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    rst_wait();
    t_strap();
    t_snoop(1'b0);
    t_snoop(1'b1);
    t_req(1'b0, 1'b1);
    t_req(1'b1, 1'b0);
    t_lock();
    t_data(1'b1);
    t_data(1'b0);
    t_sysrst();
    finish_test();
  end

  // the sequence needs a few hundred cycles; this leaves wide margin
  initial begin
    #(25 * 3000);
    n_mismatch++;
    finish_test();
  end
endmodule : host_bus_agent_signalling_bench
